// [rtl/lsa_pkg.sv]
// shared constants and types for the indicator and address strap pad logic
// assumes every input is synchronous to ref_clk; no software registers

package lsa_pkg;

  // ==========================================================
  // pad map: one index per shared pad
  localparam int LSA_NUM_PADS = 5;
  localparam int LSA_ADDR_W = 5;
  localparam int LSA_PAD_SPEED = 0;
  localparam int LSA_PAD_LINK = 1;
  localparam int LSA_PAD_ACTIVITY = 2;
  localparam int LSA_PAD_DUPLEX = 3;
  localparam int LSA_PAD_CRS = 4;

  // ==========================================================
  // reset values
  localparam logic [LSA_ADDR_W-1:0] LSA_ADDR_RST = 5'h00;
  localparam logic LSA_BIT_RST = 1'b0;
  // previous external reset level seen after rst; low so a pin already
  // high at rst release still counts as a release and straps get captured
  localparam logic LSA_EXT_PREV_RST = 1'b0;

  // ==========================================================
  // controller states, one-hot
  typedef enum logic [2:0] {
    LSA_ST_HOLD = 3'h1,
    LSA_ST_CAPTURE = 3'h2,
    LSA_ST_RUN = 3'h4
  } lsa_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic speed_100;
    logic link_up;
    logic carrier;
    logic full_duplex;
  } lsa_status_t;

  typedef struct packed {
    logic [LSA_NUM_PADS-1:0] level;
    logic [LSA_NUM_PADS-1:0] enable;
  } lsa_pad_drive_t;

  typedef struct packed {
    logic data_out;
    logic data_oe;
  } lsa_mgmt_drive_t;

endpackage

// [rtl/lsa_pad.sv]
// one shared pad: strap input while undriven, status output while running
// assumes pin_in is the resolved pad level, synchronous to ref_clk

`timescale 1ns/1ps

module lsa_pad
  import lsa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_in,
  input wire logic level_in,
  input wire logic drive_en,
  input wire logic capture,
  output logic pin_out,
  output logic pin_oe,
  output logic strap_q
);

  // ==========================================================
  // state
  typedef struct packed {
    logic out;
    logic oe;
    logic strap;
  } lsa_pad_state_t;

  lsa_pad_state_t s_q;
  lsa_pad_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (capture) begin
      s_d.strap = pin_in;
    end
    s_d.oe = drive_en;
    s_d.out = drive_en ? level_in : LSA_BIT_RST;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{out: LSA_BIT_RST, oe: LSA_BIT_RST, strap: LSA_BIT_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.out;
  assign pin_oe = s_q.oe;
  assign strap_q = s_q.strap;

endmodule // lsa_pad

// [rtl/lsa_strap_led.sv]
// status indicators, carrier sense and address straps sharing five pads,
// plus the management clock and data pins
// assumes the board resolves each pad from pin_out/pin_oe and pulls;
// all inputs are synchronous to ref_clk

`timescale 1ns/1ps

module lsa_strap_led
  import lsa_pkg::*;
#(
  parameter int NUM_PADS = LSA_NUM_PADS
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic external_reset_low,
  input wire lsa_status_t status_in,
  input wire logic [NUM_PADS-1:0] pad_in,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe,
  output logic [LSA_ADDR_W-1:0] station_addr,
  output logic station_addr_valid,
  output logic pads_driving,
  input wire logic mgmt_clk_in,
  input wire logic mgmt_data_in,
  output logic mgmt_data_out,
  output logic mgmt_data_oe,
  output logic mgmt_clk_core,
  output logic mgmt_data_core,
  input wire lsa_mgmt_drive_t mgmt_drive
);

  // ==========================================================
  // controller state
  typedef struct packed {
    lsa_state_t st;
    logic ext_prev;
    logic addr_valid;
    logic mclk;
    logic mdat_in;
    logic mdat_out;
    logic mdat_oe;
  } lsa_ctl_state_t;

  lsa_ctl_state_t c_q;
  lsa_ctl_state_t c_d;

  logic release_seen;
  logic capture;
  logic drive_en;
  lsa_pad_drive_t drive;
  logic [NUM_PADS-1:0] strap_bits;

  assign release_seen = external_reset_low && !c_q.ext_prev;
  assign capture = release_seen && (c_q.st == LSA_ST_HOLD);
  assign drive_en = (c_q.st == LSA_ST_RUN) && external_reset_low;

  // ==========================================================
  // sequencing
  always_comb begin
    c_d = c_q;
    c_d.ext_prev = external_reset_low;
    unique case (c_q.st)
      LSA_ST_HOLD: begin
        if (capture) begin
          c_d.st = LSA_ST_CAPTURE;
        end
      end
      LSA_ST_CAPTURE: begin
        // one cycle gap so straps settle before any driver turns on
        c_d.st = external_reset_low ? LSA_ST_RUN : LSA_ST_HOLD;
        c_d.addr_valid = 1'b1;
      end
      LSA_ST_RUN: begin
        // reset asserted again: release the pads for a fresh capture
        if (!external_reset_low) begin
          c_d.st = LSA_ST_HOLD;
        end
      end
      default: begin
        c_d.st = LSA_ST_HOLD;
      end
    endcase
    // management pins registered into the core
    c_d.mclk = mgmt_clk_in;
    c_d.mdat_in = mgmt_data_in;
    c_d.mdat_oe = (c_q.st == LSA_ST_RUN) && external_reset_low && mgmt_drive.data_oe;
    c_d.mdat_out = c_d.mdat_oe ? mgmt_drive.data_out : LSA_BIT_RST;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c_q <= '{st: LSA_ST_HOLD, ext_prev: LSA_EXT_PREV_RST, addr_valid: LSA_BIT_RST,
               mclk: LSA_BIT_RST, mdat_in: LSA_BIT_RST, mdat_out: LSA_BIT_RST,
               mdat_oe: LSA_BIT_RST};
    end else begin
      c_q <= c_d;
    end
  end

  // ==========================================================
  // status onto pads
  always_comb begin
    drive.level = '0;
    drive.enable = {NUM_PADS{drive_en}};
    drive.level[LSA_PAD_SPEED] = status_in.speed_100;
    drive.level[LSA_PAD_LINK] = status_in.link_up;
    drive.level[LSA_PAD_ACTIVITY] = status_in.carrier;
    drive.level[LSA_PAD_DUPLEX] = status_in.full_duplex;
    drive.level[LSA_PAD_CRS] = status_in.carrier;
  end

  // ==========================================================
  // shared pads
  for (genvar i = 0; i < NUM_PADS; i++) begin : g_pad
    lsa_pad u_pad (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin_in(pad_in[i]),
      .level_in(drive.level[i]),
      .drive_en(drive.enable[i]),
      .capture(capture),
      .pin_out(pad_out[i]),
      .pin_oe(pad_oe[i]),
      .strap_q(strap_bits[i])
    );
  end

  assign station_addr = strap_bits[LSA_ADDR_W-1:0];
  assign station_addr_valid = c_q.addr_valid;
  assign pads_driving = pad_oe[LSA_PAD_SPEED];
  assign mgmt_clk_core = c_q.mclk;
  assign mgmt_data_core = c_q.mdat_in;
  assign mgmt_data_out = c_q.mdat_out;
  assign mgmt_data_oe = c_q.mdat_oe;

endmodule // lsa_strap_led

// [tb/lsa_board.sv]
// board model: strap resistors and indicator loads on the five pads
// assumes pad_oe high means the device drives the pad
`timescale 1ns/1ps
module lsa_board
  import lsa_pkg::*;
(
  input wire logic [LSA_NUM_PADS-1:0] pad_out,
  input wire logic [LSA_NUM_PADS-1:0] pad_oe,
  input wire logic [LSA_NUM_PADS-1:0] strap,
  output logic [LSA_NUM_PADS-1:0] pad_in
);
  // ==========================================
  // pad resolution
  // strap while released
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & strap);
endmodule // lsa_board

// [tb/lsa_strap_led_assertions.sv]
// checker for strap capture, indicator pads and management pins
// assumes one clock domain and a bind onto lsa_strap_led
`timescale 1ns/1ps
module lsa_strap_led_assertions
  import lsa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic external_reset_low,
  input wire lsa_status_t status_in,
  input wire logic [4:0] pad_in,
  input wire logic [4:0] pad_out,
  input wire logic [4:0] pad_oe,
  input wire logic [4:0] station_addr,
  input wire logic station_addr_valid,
  input wire logic mgmt_clk_in,
  input wire logic mgmt_clk_core,
  input wire logic mgmt_data_out,
  input wire logic mgmt_data_oe,
  input wire lsa_mgmt_drive_t mgmt_drive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  lsa_status_t s_q;
  always_ff @(posedge ref_clk) begin
    s_q <= status_in;
  end
  // ==========================================
  // strap capture after every reset release
  // every capture: pin rises while the pads are released
  sequence cap_s;
    external_reset_low && !$past(external_reset_low) && !pad_oe[0];
  endsequence
  cap_addr_a: assert property (cap_s |=> station_addr == $past(pad_in))
    else $error("strap address wrong");
  cap_seq_a: assert property (cap_s ##1 external_reset_low [*2] |->
    station_addr_valid ##1 pad_oe == 5'h1F) else $error("capture order wrong");
  oe_off_a: assert property (!external_reset_low |=> pad_oe == 5'h00 && !mgmt_data_oe)
    else $error("driving in reset");
  idle_zero_a: assert property ((pad_out & ~pad_oe) == 5'h00)
    else $error("value on released pad");
  ind_follow_a: assert property (pad_oe == 5'h1F |-> pad_out ==
    {s_q.carrier, s_q.full_duplex, s_q.carrier, s_q.link_up, s_q.speed_100})
    else $error("indicator wrong");
  mgmt_pass_a: assert property (mgmt_data_oe |-> {mgmt_data_out, 1'b1} == $past(mgmt_drive))
    else $error("data drive wrong");
  mgmt_off_a: assert property (!mgmt_data_oe |-> !mgmt_data_out)
    else $error("data while released");
  clk_pass_a: assert property (!$past(rst) |-> mgmt_clk_core == $past(mgmt_clk_in))
    else $error("clock copy wrong");
endmodule // lsa_strap_led_assertions

bind lsa_strap_led lsa_strap_led_assertions chk_i (.ref_clk, .rst, .external_reset_low,
  .status_in, .pad_in, .pad_out, .pad_oe, .station_addr, .station_addr_valid, .mgmt_clk_in,
  .mgmt_clk_core, .mgmt_data_out, .mgmt_data_oe, .mgmt_drive);

// [tb/lsa_strap_led_tb.sv]
// testbench for the strap and indicator pads
// assumes lsa_board on the pads and the bound checker
`timescale 1ns/1ps
module lsa_strap_led_tb;
  import lsa_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic external_reset_low = 1'b0;
  lsa_status_t status_in = 4'h0;
  lsa_mgmt_drive_t mgmt_drive = 2'h0;
  logic mgmt_clk_in = 1'b0;
  logic md_tb = 1'b0;
  logic [4:0] strap = 5'h00;
  logic [4:0] pad_in, pad_out, pad_oe, station_addr;
  logic station_addr_valid, md_out, md_oe, mdc_core, md_core, mdio, pads_drv;
  int errors = 0;
  int num_checks = 0;
  // device wins the shared data pin while enabled
  assign mdio = md_oe ? md_out : md_tb;
  lsa_board board (.pad_out, .pad_oe, .strap, .pad_in);
  lsa_strap_led uut (.ref_clk, .rst, .external_reset_low, .status_in, .pad_in, .pad_out,
    .pad_oe, .station_addr, .station_addr_valid, .pads_driving(pads_drv), .mgmt_clk_in,
    .mgmt_data_in(mdio), .mgmt_data_out(md_out), .mgmt_data_oe(md_oe),
    .mgmt_clk_core(mdc_core), .mgmt_data_core(md_core), .mgmt_drive);
  always #2 ref_clk = ~ref_clk;
  // ==========================================
  // tasks
  task chk(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task t_strap(input logic [4:0] a);
    @(posedge ref_clk);
    external_reset_low <= 1'b0;
    strap <= a;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(pad_oe | {3'h0, pads_drv, md_oe}, 5'h00);
    @(posedge ref_clk);
    external_reset_low <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(station_addr, a);
    chk({4'h0, station_addr_valid}, 5'h01);
    chk(pad_oe, 5'h1F);
    chk({4'h0, pads_drv}, 5'h01);
    $display("strap test done");
  endtask
  task t_status;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      status_in <= i[3:0];
      strap <= ~strap;
      @(posedge ref_clk);
      #1;
      chk(pad_out, {i[1], i[0], i[1], i[2], i[3]});
    end
    chk(station_addr, 5'h15);
    $display("status test done");
  endtask
  task t_mgmt;
    logic e;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      mgmt_drive <= i[1:0];
      mgmt_clk_in <= i[0];
      md_tb <= ~i[1];
      #1;
      e = mdio;
      @(posedge ref_clk);
      #1;
      chk({md_oe, md_out, mdc_core, md_core, 1'b0}, {i[0], i[1] & i[0], i[0], e, 1'b0});
    end
    $display("management test done");
  endtask
  // one-cycle release: straps taken, pads must stay released
  task t_cut(input logic [4:0] a);
    @(posedge ref_clk);
    external_reset_low <= 1'b0;
    strap <= a;
    repeat (2) @(posedge ref_clk);
    external_reset_low <= 1'b1;
    @(posedge ref_clk);
    external_reset_low <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(station_addr, a);
    chk(pad_oe | {3'h0, pads_drv, md_oe}, 5'h00);
    $display("cut test done");
  endtask
  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_strap(5'h15);
    t_status;
    t_mgmt;
    t_strap(5'h0A);
    t_cut(5'h06);
    t_strap(5'h18);
    results;
  end
endmodule // lsa_strap_led_tb
